// ==== les_pkg.sv ====
// lane error readout package: register map, fields, reset values, states
package les_pkg;
    localparam logic [7:0] LES_ADDR_CTRL = 8'h15;
    localparam logic [7:0] LES_ADDR_SRC_SEL = 8'h16;
    localparam logic [7:0] LES_ADDR_L1_LO = 8'h1a;
    localparam logic [7:0] LES_ADDR_L1_HI = 8'h1b;
    localparam logic [7:0] LES_ADDR_L2_LO = 8'h1c;
    localparam logic [7:0] LES_ADDR_L2_HI = 8'h1d;
    localparam logic [7:0] LES_ADDR_L3_LO = 8'h1e;
    localparam logic [7:0] LES_ADDR_L3_HI = 8'h1f;
    localparam logic [7:0] LES_ADDR_STATUS = 8'h20;
    localparam logic [7:0] LES_ADDR_LINK_CFG = 8'h21;
    localparam int LES_CLR_BIT = 4;
    localparam int LES_PD_BIT = 7;
    localparam int LES_SB_BIT = 6;
    localparam int LES_SWAP_BIT = 0;
    localparam int LES_RATIO_BIT = 1;
    localparam int LES_CNT_W = 12;
    localparam logic [11:0] LES_CNT_MAX = 12'hfff;
    localparam logic [11:0] LES_CNT_RST = 12'h000;
    localparam logic [2:0] LES_SRC_RST = 3'h0;
    localparam logic [2:0] LES_SRC_DISP = 3'h0;
    localparam logic [2:0] LES_SRC_FIFO = 3'h1;
    localparam logic [2:0] LES_SRC_OVF = 3'h2;
    localparam logic [2:0] LES_SRC_UNF = 3'h3;
    localparam logic [2:0] LES_SRC_DESKEW = 3'h4;
    localparam logic [7:0] LES_RD_UNMAPPED = 8'h00;
    // serial slave address, arbitrary value
    localparam logic [6:0] LES_DEV_ADDR = 7'h5e;
    typedef enum logic [5:0] {
        LES_IDLE = 6'b000001,
        LES_ADDR = 6'b000010,
        LES_ACK = 6'b000100,
        LES_WRITE = 6'b001000,
        LES_READ = 6'b010000,
        LES_RACK = 6'b100000
    } les_i2c_st_t;
endpackage

// ==== les_reg_if.sv ====
// register access carrier between serial slave and register bank
`timescale 1ns/10ps
`default_nettype none
interface les_reg_if;
    logic wr_stb;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;
    modport slave (output wr_stb, output wr_addr, output wr_data,
        output rd_addr, input rd_data);
    modport bank (input wr_stb, input wr_addr, input wr_data,
        input rd_addr, output rd_data);
endinterface
`default_nettype wire

// ==== les_i2c_slave.sv ====
// serial control port slave with register pointer and auto increment
`timescale 1ns/10ps
`default_nettype none
module les_i2c_slave
    import les_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = LES_DEV_ADDR
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    les_reg_if.slave bus
);
    import les_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic [2:0] scl_q, scl_d, sda_q, sda_d;
    les_i2c_st_t st_q, st_d;
    logic [2:0] bit_q, bit_d;
    logic [7:0] sh_q, sh_d, ptr_q, ptr_d, wa_q, wa_d, wd_q, wd_d;
    logic rw_q, rw_d, drv_q, drv_d, done_q, done_d, first_q, first_d;
    logic nack_q, nack_d, stb_q, stb_d;
    logic rise, fall, start, stop;

    // stage 0 of each sync chain feeds only stage 1
    assign rise = scl_q[1] & ~scl_q[2];
    assign fall = ~scl_q[1] & scl_q[2];
    assign start = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
    assign stop = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];

    always_comb begin
        scl_d = {scl_q[1:0], scl_i};
        sda_d = {sda_q[1:0], sda_i};
        st_d = st_q;
        bit_d = bit_q;
        sh_d = sh_q;
        ptr_d = ptr_q;
        wa_d = wa_q;
        wd_d = wd_q;
        rw_d = rw_q;
        drv_d = drv_q;
        done_d = done_q;
        first_d = first_q;
        nack_d = nack_q;
        stb_d = 1'b0;
        if (start) begin
            st_d = LES_ADDR;
            bit_d = 3'h0;
            done_d = 1'b0;
            first_d = 1'b1;
            drv_d = 1'b0;
        end else if (stop) begin
            st_d = LES_IDLE;
            drv_d = 1'b0;
        end else if (rise) begin
            if (st_q == LES_ADDR || st_q == LES_WRITE) begin
                sh_d = {sh_q[6:0], sda_q[1]};
                bit_d = bit_q + 3'h1;
                done_d = (bit_q == 3'h7);
            end else if (st_q == LES_RACK) begin
                nack_d = sda_q[1];
            end
        end else if (fall) begin
            case (st_q)
                LES_ADDR: begin
                    if (done_q) begin
                        done_d = 1'b0;
                        if (sh_q[7:1] == DEV_ADDR) begin
                            st_d = LES_ACK;
                            drv_d = 1'b1;
                            rw_d = sh_q[0];
                        end else begin
                            st_d = LES_IDLE;
                        end
                    end
                end
                LES_WRITE: begin
                    if (done_q) begin
                        done_d = 1'b0;
                        st_d = LES_ACK;
                        drv_d = 1'b1;
                        first_d = 1'b0;
                        if (first_q) begin
                            ptr_d = sh_q;
                        end else begin
                            stb_d = 1'b1;
                            wa_d = ptr_q;
                            wd_d = sh_q;
                            ptr_d = ptr_q + 8'h01;
                        end
                    end
                end
                LES_ACK: begin
                    bit_d = 3'h0;
                    if (rw_q) begin
                        st_d = LES_READ;
                        sh_d = bus.rd_data;
                        drv_d = ~bus.rd_data[7];
                        ptr_d = ptr_q + 8'h01;
                    end else begin
                        st_d = LES_WRITE;
                        drv_d = 1'b0;
                    end
                end
                LES_READ: begin
                    if (bit_q == 3'h7) begin
                        st_d = LES_RACK;
                        drv_d = 1'b0;
                    end else begin
                        sh_d = {sh_q[6:0], 1'b0};
                        drv_d = ~sh_q[6];
                        bit_d = bit_q + 3'h1;
                    end
                end
                LES_RACK: begin
                    if (nack_q) begin
                        st_d = LES_IDLE;
                    end else begin
                        st_d = LES_READ;
                        bit_d = 3'h0;
                        sh_d = bus.rd_data;
                        drv_d = ~bus.rd_data[7];
                        ptr_d = ptr_q + 8'h01;
                    end
                end
                default: begin
                    st_d = LES_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            scl_q <= 3'h7;
            sda_q <= 3'h7;
            st_q <= LES_IDLE;
            bit_q <= 3'h0;
            sh_q <= 8'h00;
            ptr_q <= 8'h00;
            wa_q <= 8'h00;
            wd_q <= 8'h00;
            rw_q <= 1'b0;
            drv_q <= 1'b0;
            done_q <= 1'b0;
            first_q <= 1'b0;
            nack_q <= 1'b0;
            stb_q <= 1'b0;
        end else begin
            scl_q <= scl_d;
            sda_q <= sda_d;
            st_q <= st_d;
            bit_q <= bit_d;
            sh_q <= sh_d;
            ptr_q <= ptr_d;
            wa_q <= wa_d;
            wd_q <= wd_d;
            rw_q <= rw_d;
            drv_q <= drv_d;
            done_q <= done_d;
            first_q <= first_d;
            nack_q <= nack_d;
            stb_q <= stb_d;
        end
    end

    // open drain: only ever pulls low
    assign sda_o = 1'b0;
    assign sda_oe_n = ~drv_q;
    assign bus.wr_stb = stb_q;
    assign bus.wr_addr = wa_q;
    assign bus.wr_data = wd_q;
    assign bus.rd_addr = ptr_q;
endmodule // les_i2c_slave
`default_nettype wire

// ==== les_readout.sv ====
// lane error counter readout and power status register bank
// What this block does
// - lane1 12-bit count at 1Ah/1Bh, reset zero
// - lane2 12-bit count at 1Ch/1Dh, reset zero
// - lane3 12-bit count at 1Eh/1Fh, reset zero
// - 20h bit7 reads power-down state
// - 20h bit6 reads standby, bits 5:0 zero
// - hot plug low clears clock-ratio flag
// - selectable input lane order swap
// - clear bit rising edge zeroes counters, self-clears
// - three-bit select chooses counted error source
// - power-down clears all programmed registers
`timescale 1ns/10ps
`default_nettype none
module les_readout
    import les_pkg::*;
#(
    parameter int LANES = 4
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    input wire logic oe_pin,
    input wire logic hpd_pin,
    input wire logic clk_detect,
    input wire logic [LANES-1:0] err_disp,
    input wire logic [LANES-1:0] err_fifo,
    input wire logic [LANES-1:0] err_ovf,
    input wire logic [LANES-1:0] err_unf,
    input wire logic [LANES-1:0] deskew_stat,
    output logic power_down,
    output logic standby,
    output logic clock_ratio_flag,
    output logic lane_swap
);
    import les_pkg::*;

    function automatic logic pick_src(input logic [2:0] sel,
                                      input logic [4:0] ev);
        logic r;
        r = 1'b0;
        case (sel)
            LES_SRC_DISP: r = ev[0];
            LES_SRC_FIFO: r = ev[1];
            LES_SRC_OVF: r = ev[2];
            LES_SRC_UNF: r = ev[3];
            LES_SRC_DESKEW: r = ev[4];
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    les_reg_if bus ();

    les_i2c_slave u_slave (
        .mclk(mclk),
        .rstn(rstn),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .sda_o(sda_o),
        .sda_oe_n(sda_oe_n),
        .bus(bus)
    );

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers; stage 0 read only by stage 1
    logic [1:0] oe_q, oe_d, hpd_q, hpd_d, cdet_q, cdet_d;
    logic hpd_prev_q, hpd_prev_d, pd_q, pd_d, sb_q, sb_d;
    logic hpd_fall;

    always_comb begin
        oe_d = {oe_q[0], oe_pin};
        hpd_d = {hpd_q[0], hpd_pin};
        cdet_d = {cdet_q[0], clk_detect};
        hpd_prev_d = hpd_q[1];
        // enable low, or enable high with hot plug low, is power-down
        pd_d = ~oe_q[1] | ~hpd_q[1];
        sb_d = oe_q[1] & hpd_q[1] & ~cdet_q[1];
    end

    // oe_pin is only trusted once rails are up; sampled as a plain level
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            oe_q <= 2'h0;
            hpd_q <= 2'h0;
            cdet_q <= 2'h0;
            hpd_prev_q <= 1'b0;
            pd_q <= 1'b0;
            sb_q <= 1'b0;
        end else begin
            oe_q <= oe_d;
            hpd_q <= hpd_d;
            cdet_q <= cdet_d;
            hpd_prev_q <= hpd_prev_d;
            pd_q <= pd_d;
            sb_q <= sb_d;
        end
    end
    assign hpd_fall = hpd_prev_q & ~hpd_q[1];

    ////////////////////////////////////////////////////////////////////////
    // programmed registers
    logic clr_q, clr_d, clr_prev_q, clr_prev_d, clr_edge;
    logic [2:0] src_q, src_d;
    logic swap_q, swap_d, ratio_q, ratio_d;
    logic wr_ctrl, wr_cfg;

    assign wr_ctrl = bus.wr_stb && (bus.wr_addr == LES_ADDR_CTRL);
    assign wr_cfg = bus.wr_stb && (bus.wr_addr == LES_ADDR_LINK_CFG);
    assign clr_edge = clr_q & ~clr_prev_q;

    always_comb begin
        // a write lasts one cycle in clr_q, hence self-clearing
        clr_d = wr_ctrl & bus.wr_data[LES_CLR_BIT];
        clr_prev_d = clr_q;
        src_d = src_q;
        swap_d = swap_q;
        ratio_d = ratio_q;
        if (bus.wr_stb && bus.wr_addr == LES_ADDR_SRC_SEL) begin
            src_d = bus.wr_data[2:0];
        end
        if (hpd_fall) begin
            ratio_d = 1'b0;
        end
        // host write wins over a same-cycle hot plug drop
        if (wr_cfg) begin
            swap_d = bus.wr_data[LES_SWAP_BIT];
            ratio_d = bus.wr_data[LES_RATIO_BIT];
        end
        if (pd_q) begin
            clr_d = 1'b0;
            src_d = LES_SRC_RST;
            swap_d = 1'b0;
            ratio_d = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            clr_q <= 1'b0;
            clr_prev_q <= 1'b0;
            src_q <= LES_SRC_RST;
            swap_q <= 1'b0;
            ratio_q <= 1'b0;
        end else begin
            clr_q <= clr_d;
            clr_prev_q <= clr_prev_d;
            src_q <= src_d;
            swap_q <= swap_d;
            ratio_q <= ratio_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-lane event selection; swap reverses physical lane order
    logic [LANES-1:0] lane_evt;
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            localparam int PHYS = LANES - 1 - g;
            logic [4:0] ev_str, ev_swp;
            assign ev_str = {deskew_stat[g], err_unf[g], err_ovf[g],
                             err_fifo[g], err_disp[g]};
            assign ev_swp = {deskew_stat[PHYS], err_unf[PHYS], err_ovf[PHYS],
                             err_fifo[PHYS], err_disp[PHYS]};
            assign lane_evt[g] = pick_src(src_q,
                swap_q ? ev_swp : ev_str);
        end
    endgenerate

    // lanes 1..3 only; lane 0 lives in another bank
    logic [LES_CNT_W-1:0] cnt_q [1:3];
    logic [LES_CNT_W-1:0] cnt_d [1:3];

    always_comb begin
        for (int l = 1; l <= 3; l++) begin
            cnt_d[l] = cnt_q[l];
            if (pd_q || clr_edge) begin
                cnt_d[l] = LES_CNT_RST;
            end else if (lane_evt[l] && cnt_q[l] != LES_CNT_MAX) begin
                cnt_d[l] = cnt_q[l] + 12'h001;
            end
        end
    end

    always_ff @(posedge mclk) begin
        for (int l = 1; l <= 3; l++) begin
            if (!rstn) begin
                cnt_q[l] <= LES_CNT_RST;
            end else begin
                cnt_q[l] <= cnt_d[l];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read decode
    always_comb begin
        bus.rd_data = LES_RD_UNMAPPED;
        if (bus.rd_addr == LES_ADDR_CTRL) begin
            bus.rd_data = {3'h0, clr_q, 4'h0};
        end else if (bus.rd_addr == LES_ADDR_SRC_SEL) begin
            bus.rd_data = {5'h00, src_q};
        end else if (bus.rd_addr == LES_ADDR_L1_LO) begin
            bus.rd_data = cnt_q[1][7:0];
        end else if (bus.rd_addr == LES_ADDR_L1_HI) begin
            bus.rd_data = {4'h0, cnt_q[1][11:8]};
        end else if (bus.rd_addr == LES_ADDR_L2_LO) begin
            bus.rd_data = cnt_q[2][7:0];
        end else if (bus.rd_addr == LES_ADDR_L2_HI) begin
            bus.rd_data = {4'h0, cnt_q[2][11:8]};
        end else if (bus.rd_addr == LES_ADDR_L3_LO) begin
            bus.rd_data = cnt_q[3][7:0];
        end else if (bus.rd_addr == LES_ADDR_L3_HI) begin
            bus.rd_data = {4'h0, cnt_q[3][11:8]};
        end else if (bus.rd_addr == LES_ADDR_STATUS) begin
            bus.rd_data = {pd_q, sb_q, 6'h00};
        end else if (bus.rd_addr == LES_ADDR_LINK_CFG) begin
            bus.rd_data = {6'h00, ratio_q, swap_q};
        end
    end

    assign power_down = pd_q;
    assign standby = sb_q;
    assign clock_ratio_flag = ratio_q;
    assign lane_swap = swap_q;

    ////////////////////////////////////////////////////////////////////////
    a_cnt_clear: assert property (@(posedge mclk)
        disable iff (!rstn)
        $rose(clr_q) |=> (cnt_q[1] == 12'h000 && cnt_q[2] == 12'h000
                          && cnt_q[3] == 12'h000))
        else $error("counters not cleared by clear edge");
    a_clr_self: assert property (@(posedge mclk)
        disable iff (!rstn)
        clr_q |=> !clr_q)
        else $error("clear bit did not self-clear");
    a_cnt_saturate: assert property (@(posedge mclk)
        disable iff (!rstn)
        (cnt_q[1] == 12'hfff && !clr_edge && !pd_q) |=> cnt_q[1] == 12'hfff)
        else $error("lane1 counter wrapped");
    a_cnt_count: assert property (@(posedge mclk)
        disable iff (!rstn)
        (lane_evt[3] && !clr_edge && !pd_q && cnt_q[3] != 12'hfff)
        |=> cnt_q[3] == $past(cnt_q[3]) + 12'h001)
        else $error("lane3 counter missed an event");
    a_src_reserved: assert property (@(posedge mclk)
        disable iff (!rstn)
        (src_q == 3'h5) |-> lane_evt == '0)
        else $error("reserved source produced events");
    a_pd_status: assert property (@(posedge mclk)
        disable iff (!rstn)
        (!oe_q[1]) |=> (power_down && bus.rd_addr != 8'h20
                        || bus.rd_data[7]))
        else $error("power-down status not shown");
    a_sb_status: assert property (@(posedge mclk)
        disable iff (!rstn)
        (bus.rd_addr == 8'h20) |-> (bus.rd_data[5:0] == 6'h00
                                    && bus.rd_data[6] == standby))
        else $error("status register bits wrong");
    a_hi_nibble: assert property (@(posedge mclk)
        disable iff (!rstn)
        (bus.rd_addr == 8'h1d) |-> bus.rd_data[7:4] == 4'h0)
        else $error("lane2 reserved bits nonzero");
    a_ratio_hpd: assert property (@(posedge mclk)
        disable iff (!rstn)
        (hpd_fall && !wr_cfg) |=> !clock_ratio_flag)
        else $error("ratio flag survived hot plug drop");
    a_pd_clears: assert property (@(posedge mclk)
        disable iff (!rstn)
        pd_q |=> (src_q == 3'h0 && !lane_swap && !clock_ratio_flag
                  && cnt_q[1] == 12'h000))
        else $error("power-down left registers set");
    a_swap_map: assert property (@(posedge mclk)
        disable iff (!rstn)
        (lane_swap && src_q == 3'h0) |-> lane_evt[1] == err_disp[2])
        else $error("swapped lane mapping wrong");
endmodule // les_readout
`default_nettype wire

// ==== les_host_model.sv ====
// serial host model: open-drain bus master, sda pulled up
`timescale 1ns/10ps
`default_nettype none
module les_host_model (
    input wire logic mclk,
    input wire logic sda_oe_n,
    output logic scl,
    output logic sda
);
    import les_pkg::*;
    logic sda_q;
    int nacks;
    // pull-up: the wire is low only while some party pulls it
    assign sda = sda_q & sda_oe_n;
    initial begin
        scl = 1'b1;
        sda_q = 1'b1;
        nacks = 0;
    end
    ////////////////////////////////////////////////////////////////////////
    // each phase lasts 6 cycles, above the 4 cycle minimum
    task automatic put(input logic s, input logic c);
        @(posedge mclk);
        sda_q <= s;
        scl <= c;
        repeat (5) @(posedge mclk);
    endtask
    // data moves only while scl is low, never on the falling edge itself
    task automatic bitx(input logic b, output logic v);
        put(sda_q, 1'b0);
        put(b, 1'b0);
        put(b, 1'b1);
        v = sda;
    endtask
    task automatic start();
        put(sda_q, 1'b0);
        put(1'b1, 1'b0);
        put(1'b1, 1'b1);
        put(1'b0, 1'b1);
    endtask
    task automatic stop();
        put(sda_q, 1'b0);
        put(1'b0, 1'b0);
        put(1'b0, 1'b1);
        put(1'b1, 1'b1);
    endtask
    task automatic sb(input logic [7:0] d);
        logic v;
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], v);
        end
        bitx(1'b1, v);
        if (v !== 1'b0) begin
            nacks++;
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        start();
        sb({LES_DEV_ADDR, 1'b0});
        sb(a);
        sb(d);
        stop();
    endtask
    // single byte read ends with a nack from the host
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        logic v;
        start();
        sb({LES_DEV_ADDR, 1'b0});
        sb(a);
        start();
        sb({LES_DEV_ADDR, 1'b1});
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b1, d[i]);
        end
        bitx(1'b1, v);
        stop();
    endtask
endmodule // les_host_model
`default_nettype wire

// ==== lane_error_status_readout_tb_top.sv ====
// self-checking bench for the lane error readout register bank
`timescale 1ns/10ps
`default_nettype none
module lane_error_status_readout_tb_top;
    import les_pkg::*;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic oe_pin = 1'b1;
    logic hpd_pin = 1'b1;
    logic clk_detect = 1'b1;
    logic [4:0][3:0] ev = '0;
    logic scl, sda, sda_o, sda_oe_n;
    logic power_down, standby, clock_ratio_flag, lane_swap;
    int num_errors = 0;
    int n_compared = 0;
    int cyc = 0;
    always #12.5 mclk = ~mclk;
    les_host_model i_host (.mclk(mclk), .sda_oe_n(sda_oe_n), .scl(scl),
        .sda(sda));
    les_readout i_dut (.mclk(mclk), .rstn(rstn), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_n(sda_oe_n), .oe_pin(oe_pin),
        .hpd_pin(hpd_pin), .clk_detect(clk_detect), .err_disp(ev[0]),
        .err_fifo(ev[1]), .err_ovf(ev[2]), .err_unf(ev[3]),
        .deskew_stat(ev[4]), .power_down(power_down), .standby(standby),
        .clock_ratio_flag(clock_ratio_flag), .lane_swap(lane_swap));
    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // ceiling well above the roughly 55000 cycles the sequence needs
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        i_host.rd_reg(a, v);
        chk(v, exp);
    endtask
    // counters are read low byte then high byte, upper nibble reads zero
    task automatic rd_cnt(input int l, input logic [11:0] exp);
        logic [7:0] a;
        a = 8'(LES_ADDR_L1_LO + 2 * (l - 1));
        rchk(a, exp[7:0]);
        rchk(a + 8'h01, {4'h0, exp[11:8]});
    endtask
    task automatic pulse(input int s, input logic [3:0] p, input int n);
        @(posedge mclk);
        ev[s] <= p;
        repeat (n) @(posedge mclk);
        ev[s] <= 4'h0;
    endtask
    task automatic pins(input logic o, input logic h, input logic c);
        @(posedge mclk);
        oe_pin <= o;
        hpd_pin <= h;
        clk_detect <= c;
        repeat (6) @(posedge mclk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge mclk);
        rstn <= 1'b1;
        repeat (8) @(posedge mclk);
        for (int a = 8'h1a; a <= 8'h20; a++) begin
            rchk(8'(a), 8'h00);
        end
        $display("test reset_values done");
        // each source counted alone; the next source in line must not count
        for (int s = 0; s < 5; s++) begin
            i_host.wr_reg(LES_ADDR_CTRL, 8'h10);
            i_host.wr_reg(LES_ADDR_SRC_SEL, 8'(s));
            pulse(s, 4'b1110, s + 2);
            pulse((s + 1) % 5, 4'b1110, 4);
            for (int l = 1; l < 4; l++) begin
                rd_cnt(l, 12'(s + 2));
            end
        end
        $display("test source_select done");
        i_host.wr_reg(LES_ADDR_CTRL, 8'h10);
        i_host.wr_reg(LES_ADDR_SRC_SEL, 8'h00);
        i_host.wr_reg(LES_ADDR_LINK_CFG, 8'h01);
        chk({7'h0, lane_swap}, 8'h01);
        pulse(0, 4'b0010, 3);
        rd_cnt(1, 12'h000);
        rd_cnt(2, 12'h003);
        $display("test lane_swap done");
        i_host.wr_reg(LES_ADDR_LINK_CFG, 8'h00);
        pulse(0, 4'b0010, 4100);
        rd_cnt(1, LES_CNT_MAX);
        i_host.wr_reg(LES_ADDR_CTRL, 8'h10);
        rd_cnt(1, 12'h000);
        rchk(LES_ADDR_CTRL, 8'h00);
        $display("test saturate_clear done");
        i_host.wr_reg(LES_ADDR_SRC_SEL, 8'h03);
        i_host.wr_reg(LES_ADDR_LINK_CFG, 8'h02);
        chk({7'h0, clock_ratio_flag}, 8'h01);
        rchk(LES_ADDR_LINK_CFG, 8'h02);
        pulse(3, 4'b0010, 5);
        pins(1'b1, 1'b0, 1'b1);
        chk({7'h0, clock_ratio_flag}, 8'h00);
        chk({7'h0, power_down}, 8'h01);
        rchk(LES_ADDR_STATUS, 8'h80);
        pins(1'b1, 1'b1, 1'b1);
        chk({7'h0, power_down}, 8'h00);
        rchk(LES_ADDR_LINK_CFG, 8'h00);
        rchk(LES_ADDR_SRC_SEL, 8'h00);
        rd_cnt(1, 12'h000);
        $display("test power_down done");
        pins(1'b1, 1'b1, 1'b0);
        chk({7'h0, standby}, 8'h01);
        rchk(LES_ADDR_STATUS, 8'h40);
        pins(1'b1, 1'b1, 1'b1);
        rchk(8'h30, LES_RD_UNMAPPED);
        pins(1'b0, 1'b1, 1'b1);
        chk({7'h0, power_down}, 8'h01);
        pins(1'b1, 1'b1, 1'b1);
        // reserved select code 5 must count nothing on any source
        i_host.wr_reg(LES_ADDR_SRC_SEL, 8'h05);
        rchk(LES_ADDR_SRC_SEL, 8'h05);
        for (int s = 0; s < 5; s++) begin
            pulse(s, 4'b1110, 2);
        end
        rd_cnt(3, 12'h000);
        chk({7'h0, sda_o}, 8'h00);
        chk(8'(i_host.nacks), 8'h00);
        $display("test standby_oe done");
        tally_and_finish();
    end
endmodule // lane_error_status_readout_tb_top
`default_nettype wire
